// ===== verilog/cmc_pkg.sv
// shared constants and types for the codec channel mute and power control block
package cmc_pkg;

    // ==========================================================
    // register offsets (7-bit control word address)
    localparam logic [6:0] ADDR_DAC_GLOBAL = 7'h02;
    localparam logic [6:0] ADDR_DAC_INVERT = 7'h03;
    localparam logic [6:0] ADDR_DAC_CHANNEL = 7'h09;
    localparam logic [6:0] ADDR_POWER = 7'h0A;
    localparam logic [6:0] ADDR_ADC_SILENCE = 7'h0C;
    localparam logic [6:0] ADDR_STATUS = 7'h0D;

    // ==========================================================
    // reset values
    localparam logic [8:0] RST_DAC_GLOBAL = 9'h000;
    localparam logic [8:0] RST_DAC_INVERT = 9'h000;
    localparam logic [8:0] RST_DAC_CHANNEL = 9'h000;
    localparam logic [8:0] RST_POWER = 9'h000;
    localparam logic [8:0] RST_ADC_SILENCE = 9'h000;
    localparam logic [7:0] RST_VOLUME = 8'hFF;

    // ==========================================================
    // field positions
    localparam int GLB_SOFT_SILENCE = 0;
    localparam int GLB_EMPHASIS_UNDO = 1;
    localparam int GLB_DAC_SHUTDOWN = 2;
    localparam int INV_LSB = 6;
    localparam int CH_ZERO_CROSS_DISABLE = 0;
    localparam int CH_FLAG_SEL_LSB = 1;
    localparam int CH_SOFT_SILENCE_LSB = 3;
    localparam int CH_EMPHASIS_LSB = 6;
    localparam int PWR_ADC_DISABLE = 0;
    localparam int PWR_DAC_DISABLE_LSB = 1;
    localparam int PWR_REFERENCE = 4;
    localparam int ADC_RIGHT = 0;
    localparam int ADC_LEFT = 1;
    localparam int ADC_BOTH = 2;

    // ==========================================================
    // timing and ramp constants
    localparam logic [10:0] ZERO_RUN = 11'h400;
    localparam logic [2:0] INIT_LAST = 3'h3;
    localparam logic [7:0] GAIN_FULL = 8'h80;
    localparam logic [7:0] GAIN_STEP = 8'h08;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_DOWN = 2'b01,
        PWR_INIT = 2'b10
    } cmc_pwr_state_type;

    typedef struct packed {
        cmc_pwr_state_type state;
        logic [2:0] count;
    } cmc_pwr_type;

    typedef struct packed {
        logic [5:0][23:0] ch;
    } cmc_frame_type;

    typedef struct packed {
        logic [5:0][7:0] vol;
    } cmc_volume_type;

endpackage : cmc_pkg

// ===== verilog/cmc_chan.sv
// one mono dac channel: zero run, gated volume update, soft ramp, inversion
`timescale 1ns/1ns
module cmc_chan (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic in_valid,
    input wire logic [23:0] in_sample,
    input wire logic [7:0] volume_req,
    input wire logic zc_gate,
    input wire logic soft_mute,
    input wire logic invert,
    input wire logic flush,
    output logic [23:0] out_sample,
    output logic [7:0] volume_now,
    output logic zero_flag
);
    logic [10:0] zero_count;
    logic [10:0] next_zero_count;
    logic prev_neg;
    logic next_prev_neg;
    logic [7:0] gain;
    logic [7:0] next_gain;
    logic [7:0] next_volume_now;
    logic [23:0] next_out_sample;
    logic next_zero_flag;
    logic crossing;
    logic signed [32:0] product;
    logic [23:0] scaled;

    // ==========================================================
    // per-sample next state
    always_comb begin
        next_zero_count = zero_count;
        next_prev_neg = prev_neg;
        next_gain = gain;
        next_volume_now = volume_now;
        next_out_sample = out_sample;
        product = $signed(in_sample) * $signed({1'b0, gain});
        scaled = product[30:7];
        crossing = (in_sample == 24'h000000) || (in_sample[23] != prev_neg);
        if (flush) begin
            // history dropped, output silenced at once
            next_zero_count = 11'h000;
            next_prev_neg = 1'b0;
            next_gain = soft_mute ? 8'h00 : cmc_pkg::GAIN_FULL;
            next_out_sample = 24'h000000;
        end else if (in_valid) begin
            if (!zc_gate || crossing) begin
                next_volume_now = volume_req;
            end
            next_prev_neg = in_sample[23];
            if (in_sample != 24'h000000) begin
                next_zero_count = 11'h000;
            end else if (zero_count != cmc_pkg::ZERO_RUN) begin
                next_zero_count = zero_count + 11'h001;
            end
            if (soft_mute) begin
                next_gain = (gain > cmc_pkg::GAIN_STEP) ? gain - cmc_pkg::GAIN_STEP : 8'h00;
            end else begin
                next_gain = (gain < cmc_pkg::GAIN_FULL - cmc_pkg::GAIN_STEP) ?
                    gain + cmc_pkg::GAIN_STEP : cmc_pkg::GAIN_FULL;
            end
            // negation of full-scale negative wraps; accepted
            next_out_sample = invert ? 24'h000000 - scaled : scaled;
        end
        next_zero_flag = (next_zero_count == cmc_pkg::ZERO_RUN);
    end

    // register the channel state
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            zero_count <= 11'h000;
            prev_neg <= 1'b0;
            gain <= cmc_pkg::GAIN_FULL;
            volume_now <= cmc_pkg::RST_VOLUME;
            out_sample <= 24'h000000;
            zero_flag <= 1'b0;
        end else begin
            zero_count <= next_zero_count;
            prev_neg <= next_prev_neg;
            gain <= next_gain;
            volume_now <= next_volume_now;
            out_sample <= next_out_sample;
            zero_flag <= next_zero_flag;
        end
    end

    // ==========================================================
    // checks
    sequence s_live_sample;
        in_valid && !flush;
    endsequence

    a_zero_nonzero: assert property (@(posedge core_clk) disable iff (!rstn)
        (s_live_sample and (in_sample != 24'h000000)) |=> !zero_flag)
        else $error("zero flag set after a nonzero sample");
    a_zero_count: assert property (@(posedge core_clk) disable iff (!rstn)
        zero_flag |-> zero_count == 11'h400)
        else $error("zero flag without full zero run");
    a_volume_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        (s_live_sample and (zc_gate && !crossing)) |=> $stable(volume_now))
        else $error("volume changed without a zero crossing");
    a_volume_free: assert property (@(posedge core_clk) disable iff (!rstn)
        (s_live_sample and !zc_gate) |=> volume_now == $past(volume_req))
        else $error("ungated volume not applied");
    a_mute_ramp: assert property (@(posedge core_clk) disable iff (!rstn)
        (s_live_sample and (soft_mute && gain > 8'h08)) |=> gain == $past(gain) - 8'h08)
        else $error("soft mute gain did not step down");
    a_flush_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
        flush |=> (out_sample == 24'h000000) && (zero_count == 11'h000))
        else $error("flush left history behind");

endmodule : cmc_chan

// ===== verilog/cmc_ctrl.sv
// control registers and channel effects for the codec mute and power block
// Contract
// - each invert bit negates both outputs of its stereo dac pair
// - with gating on, a new volume waits for a zero crossing
// - zero-cross disable bit, reset 0; 1 applies volume changes at once
// - zero flag rises after 1024 consecutive zero samples on selected channels
// - flag select: 00 all, 01 pair 1, 10 pair 2, 11 pair 3
// - per-pair soft mute field mutes the selected dac pairs softly
// - global soft mute bit mutes all dac pairs softly
// - shutdown mute may silence the output abruptly, without a ramp
// - adc silence bits: right, left, both; zero is normal
// - per-pair de-emphasis field enables de-emphasis on selected pairs
// - global de-emphasis bit enables de-emphasis on all pairs
// - global dac shutdown overrides per-pair disables and stops all dacs
// - during shutdown sample history is dropped, registers are kept
// - clearing shutdown reinitialises the dac filters before running again
// - adc disable bit resets adc filters; they reinitialise on clear
// - per-pair dac disable field stops each selected pair
// - reference shutdown bit powers down the chip references
`timescale 1ns/1ns
module cmc_ctrl (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ctrl_wr,
    input wire logic ctrl_rd,
    input wire logic [6:0] ctrl_addr,
    input wire logic [8:0] ctrl_data,
    output logic [8:0] rd_data,
    input wire logic in_valid,
    input wire cmc_pkg::cmc_frame_type in_frame,
    input wire cmc_pkg::cmc_volume_type volume_req,
    output logic out_valid,
    output cmc_pkg::cmc_frame_type out_frame,
    output cmc_pkg::cmc_volume_type volume_applied,
    output logic silence_flag_pin,
    output logic [2:0] emphasis_on,
    output logic [2:0] dac_enable,
    output logic dac_filter_reset,
    output logic adc_enable,
    output logic adc_filter_reset,
    output logic adc_left_mute,
    output logic adc_right_mute,
    output logic reference_power_down
);
    logic [8:0] dac_global_ctrl;
    logic [8:0] dac_invert_ctrl;
    logic [8:0] dac_channel_ctrl;
    logic [8:0] power_ctrl;
    logic [8:0] adc_silence_ctrl;
    logic [8:0] next_dac_global_ctrl;
    logic [8:0] next_dac_invert_ctrl;
    logic [8:0] next_dac_channel_ctrl;
    logic [8:0] next_power_ctrl;
    logic [8:0] next_adc_silence_ctrl;
    logic [8:0] next_rd_data;
    logic dac_shutdown_all;
    logic global_soft_silence;
    logic global_emphasis_undo;
    logic volume_crossing_enable;
    logic [1:0] zero_flag_select;
    logic [2:0] per_channel_soft_silence;
    logic [2:0] per_channel_emphasis_undo;
    logic [2:0] dac_pair_disable;
    logic [2:0] pair_invert;
    logic adc_disable_bit;
    cmc_pkg::cmc_pwr_type dac_pwr;
    cmc_pkg::cmc_pwr_type adc_pwr;
    cmc_pkg::cmc_pwr_type next_dac_pwr;
    cmc_pkg::cmc_pwr_type next_adc_pwr;
    logic [5:0] chan_zero;
    logic [2:0] pair_zero;
    logic next_out_valid;
    logic next_silence_flag_pin;
    logic [2:0] next_emphasis_on;
    logic [2:0] next_dac_enable;
    logic next_dac_filter_reset;
    logic next_adc_enable;
    logic next_adc_filter_reset;
    logic next_adc_left_mute;
    logic next_adc_right_mute;

    // ==========================================================
    // field views of the stored registers
    assign global_soft_silence = dac_global_ctrl[cmc_pkg::GLB_SOFT_SILENCE];
    assign global_emphasis_undo = dac_global_ctrl[cmc_pkg::GLB_EMPHASIS_UNDO];
    assign dac_shutdown_all = dac_global_ctrl[cmc_pkg::GLB_DAC_SHUTDOWN];
    assign pair_invert = dac_invert_ctrl[cmc_pkg::INV_LSB +: 3];
    assign volume_crossing_enable = !dac_channel_ctrl[cmc_pkg::CH_ZERO_CROSS_DISABLE];
    assign zero_flag_select = dac_channel_ctrl[cmc_pkg::CH_FLAG_SEL_LSB +: 2];
    assign per_channel_soft_silence = dac_channel_ctrl[cmc_pkg::CH_SOFT_SILENCE_LSB +: 3];
    assign per_channel_emphasis_undo = dac_channel_ctrl[cmc_pkg::CH_EMPHASIS_LSB +: 3];
    assign adc_disable_bit = power_ctrl[cmc_pkg::PWR_ADC_DISABLE];
    assign dac_pair_disable = power_ctrl[cmc_pkg::PWR_DAC_DISABLE_LSB +: 3];
    assign reference_power_down = power_ctrl[cmc_pkg::PWR_REFERENCE];

    // ==========================================================
    // power sequencing step shared by the dac and adc paths
    function automatic cmc_pkg::cmc_pwr_type pwr_step(
        input cmc_pkg::cmc_pwr_type cur,
        input logic down
    );
        cmc_pkg::cmc_pwr_type nxt;
        nxt = cur;
        case (cur.state)
            cmc_pkg::PWR_RUN: begin
                if (down) begin
                    nxt.state = cmc_pkg::PWR_DOWN;
                end
            end
            cmc_pkg::PWR_DOWN: begin
                if (!down) begin
                    nxt.state = cmc_pkg::PWR_INIT;
                    nxt.count = cmc_pkg::INIT_LAST;
                end
            end
            cmc_pkg::PWR_INIT: begin
                if (down) begin
                    nxt.state = cmc_pkg::PWR_DOWN;
                end else if (cur.count == 3'h0) begin
                    nxt.state = cmc_pkg::PWR_RUN;
                end else begin
                    nxt.count = cur.count - 3'h1;
                end
            end
            default: begin
                nxt.state = cmc_pkg::PWR_DOWN;
            end
        endcase
        return nxt;
    endfunction : pwr_step

    // zero flag source picked by the select field
    function automatic logic flag_pick(input logic [1:0] sel, input logic [2:0] pz);
        logic pick;
        case (sel)
            2'b00: pick = &pz;
            2'b01: pick = pz[0];
            2'b10: pick = pz[1];
            2'b11: pick = pz[2];
            default: pick = 1'b0;
        endcase
        return pick;
    endfunction : flag_pick

    // ==========================================================
    // register writes and registered read port
    always_comb begin
        next_dac_global_ctrl = dac_global_ctrl;
        next_dac_invert_ctrl = dac_invert_ctrl;
        next_dac_channel_ctrl = dac_channel_ctrl;
        next_power_ctrl = power_ctrl;
        next_adc_silence_ctrl = adc_silence_ctrl;
        next_rd_data = rd_data;
        if (ctrl_wr) begin
            case (ctrl_addr)
                cmc_pkg::ADDR_DAC_GLOBAL: next_dac_global_ctrl = ctrl_data;
                cmc_pkg::ADDR_DAC_INVERT: next_dac_invert_ctrl = ctrl_data;
                cmc_pkg::ADDR_DAC_CHANNEL: next_dac_channel_ctrl = ctrl_data;
                cmc_pkg::ADDR_POWER: next_power_ctrl = ctrl_data;
                cmc_pkg::ADDR_ADC_SILENCE: next_adc_silence_ctrl = ctrl_data;
                default: next_rd_data = rd_data; // unmapped writes ignored
            endcase
        end
        if (ctrl_rd) begin
            case (ctrl_addr)
                cmc_pkg::ADDR_DAC_GLOBAL: next_rd_data = dac_global_ctrl;
                cmc_pkg::ADDR_DAC_INVERT: next_rd_data = dac_invert_ctrl;
                cmc_pkg::ADDR_DAC_CHANNEL: next_rd_data = dac_channel_ctrl;
                cmc_pkg::ADDR_POWER: next_rd_data = power_ctrl;
                cmc_pkg::ADDR_ADC_SILENCE: next_rd_data = adc_silence_ctrl;
                cmc_pkg::ADDR_STATUS: next_rd_data = {1'b0, dac_filter_reset, adc_filter_reset,
                    chan_zero};
                default: next_rd_data = 9'h000;
            endcase
        end
    end

    // register file; shutdown never touches these values
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dac_global_ctrl <= cmc_pkg::RST_DAC_GLOBAL;
            dac_invert_ctrl <= cmc_pkg::RST_DAC_INVERT;
            dac_channel_ctrl <= cmc_pkg::RST_DAC_CHANNEL;
            power_ctrl <= cmc_pkg::RST_POWER;
            adc_silence_ctrl <= cmc_pkg::RST_ADC_SILENCE;
            rd_data <= 9'h000;
        end else begin
            dac_global_ctrl <= next_dac_global_ctrl;
            dac_invert_ctrl <= next_dac_invert_ctrl;
            dac_channel_ctrl <= next_dac_channel_ctrl;
            power_ctrl <= next_power_ctrl;
            adc_silence_ctrl <= next_adc_silence_ctrl;
            rd_data <= next_rd_data;
        end
    end

    // ==========================================================
    // power sequencing and control outputs
    always_comb begin
        next_dac_pwr = pwr_step(dac_pwr, dac_shutdown_all);
        next_adc_pwr = pwr_step(adc_pwr, adc_disable_bit);
        next_dac_filter_reset = (next_dac_pwr.state != cmc_pkg::PWR_RUN);
        next_adc_filter_reset = (next_adc_pwr.state != cmc_pkg::PWR_RUN);
        next_adc_enable = !adc_disable_bit;
        next_dac_enable = dac_shutdown_all ? 3'b000 : ~dac_pair_disable;
        next_emphasis_on = per_channel_emphasis_undo | {3{global_emphasis_undo}};
        next_adc_right_mute = adc_silence_ctrl[cmc_pkg::ADC_RIGHT] |
            adc_silence_ctrl[cmc_pkg::ADC_BOTH];
        next_adc_left_mute = adc_silence_ctrl[cmc_pkg::ADC_LEFT] |
            adc_silence_ctrl[cmc_pkg::ADC_BOTH];
        next_silence_flag_pin = flag_pick(zero_flag_select, pair_zero);
        next_out_valid = in_valid && !dac_filter_reset;
    end

    // register the control outputs
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dac_pwr <= '{state: cmc_pkg::PWR_RUN, count: 3'h0};
            adc_pwr <= '{state: cmc_pkg::PWR_RUN, count: 3'h0};
            dac_filter_reset <= 1'b0;
            adc_filter_reset <= 1'b0;
            adc_enable <= 1'b1;
            dac_enable <= 3'b111;
            emphasis_on <= 3'b000;
            adc_right_mute <= 1'b0;
            adc_left_mute <= 1'b0;
            silence_flag_pin <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            dac_pwr <= next_dac_pwr;
            adc_pwr <= next_adc_pwr;
            dac_filter_reset <= next_dac_filter_reset;
            adc_filter_reset <= next_adc_filter_reset;
            adc_enable <= next_adc_enable;
            dac_enable <= next_dac_enable;
            emphasis_on <= next_emphasis_on;
            adc_right_mute <= next_adc_right_mute;
            adc_left_mute <= next_adc_left_mute;
            silence_flag_pin <= next_silence_flag_pin;
            out_valid <= next_out_valid;
        end
    end

    // ==========================================================
    // six mono channels, two per stereo pair
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_chan
            cmc_chan u_chan (
                .core_clk(core_clk),
                .rstn(rstn),
                .in_valid(in_valid),
                .in_sample(in_frame.ch[gi]),
                .volume_req(volume_req.vol[gi]),
                .zc_gate(volume_crossing_enable),
                .soft_mute(per_channel_soft_silence[gi / 2] | global_soft_silence),
                .invert(pair_invert[gi / 2]),
                .flush(dac_filter_reset | dac_pair_disable[gi / 2]),
                .out_sample(out_frame.ch[gi]),
                .volume_now(volume_applied.vol[gi]),
                .zero_flag(chan_zero[gi])
            );
        end
        for (gi = 0; gi < 3; gi++) begin : g_pair
            assign pair_zero[gi] = chan_zero[2 * gi] & chan_zero[2 * gi + 1];
        end
    endgenerate

    // ==========================================================
    // checks
    sequence s_release;
        dac_pwr.state == cmc_pkg::PWR_DOWN && !dac_shutdown_all;
    endsequence

    a_shutdown_override: assert property (@(posedge core_clk) disable iff (!rstn)
        dac_shutdown_all |=> dac_enable == 3'b000)
        else $error("dacs enabled during global shutdown");
    a_release_init: assert property (@(posedge core_clk) disable iff (!rstn)
        s_release |=> dac_filter_reset [*4])
        else $error("dac filters not held in reinit after release");
    a_init_done: assert property (@(posedge core_clk) disable iff (!rstn)
        (dac_pwr.state == cmc_pkg::PWR_INIT && dac_pwr.count == 3'h0 && !dac_shutdown_all)
        |=> !dac_filter_reset)
        else $error("dac reinit did not finish");
    a_adc_reset: assert property (@(posedge core_clk) disable iff (!rstn)
        adc_disable_bit |=> adc_filter_reset && !adc_enable)
        else $error("adc filters not reset while disabled");
    a_pair_disable: assert property (@(posedge core_clk) disable iff (!rstn)
        (dac_pair_disable[0] && !ctrl_wr) |=> !dac_enable[0])
        else $error("disabled pair still enabled");
    a_reference_write: assert property (@(posedge core_clk) disable iff (!rstn)
        (ctrl_wr && ctrl_addr == 7'h0A) |=> reference_power_down == $past(ctrl_data[4]))
        else $error("reference shutdown did not follow write");
    a_adc_silence: assert property (@(posedge core_clk) disable iff (!rstn)
        adc_silence_ctrl[2] |=> adc_left_mute && adc_right_mute)
        else $error("both-channel adc silence not applied");
    a_emphasis_all: assert property (@(posedge core_clk) disable iff (!rstn)
        global_emphasis_undo |=> emphasis_on == 3'b111)
        else $error("global de-emphasis not applied");
    a_flag_pair: assert property (@(posedge core_clk) disable iff (!rstn)
        (zero_flag_select == 2'b01 && !pair_zero[0]) |=> !silence_flag_pin)
        else $error("zero flag shows unselected pair");

endmodule : cmc_ctrl

// ===== sim/cmc_host.sv
// host model driving the control port with one word per access
`timescale 1ns/1ns
module cmc_host (
    input wire logic core_clk,
    output logic ctrl_wr,
    output logic ctrl_rd,
    output logic [6:0] ctrl_addr,
    output logic [8:0] ctrl_data
);
    // ==========
    // idle bus at time zero
    initial begin
        ctrl_wr = 1'h0;
        ctrl_rd = 1'h0;
        ctrl_addr = 7'h00;
        ctrl_data = 9'h000;
    end
    // one strobe cycle; data inverted after so a stale word never looks valid
    task automatic acc(input logic w, input logic [6:0] a, input logic [8:0] d);
        @(posedge core_clk);
        ctrl_wr <= w;
        ctrl_rd <= ~w;
        ctrl_addr <= a;
        ctrl_data <= d;
        @(posedge core_clk);
        ctrl_wr <= 1'h0;
        ctrl_rd <= 1'h0;
        ctrl_data <= ~d;
    endtask : acc
endmodule : cmc_host

// ===== sim/testbench.sv
// self-checking bench for the channel mute and power control block
`timescale 1ns/1ns
module testbench;
    logic core_clk = 1'h0;
    logic rstn = 1'h0;
    logic ctrl_wr, ctrl_rd, in_valid = 1'h0, out_valid, silence_flag_pin, dac_filter_reset;
    logic adc_enable, adc_filter_reset, adc_left_mute, adc_right_mute, reference_power_down;
    logic [6:0] ctrl_addr;
    logic [8:0] ctrl_data, rd_data;
    logic [2:0] emphasis_on, dac_enable;
    cmc_pkg::cmc_frame_type in_frame = '0, out_frame;
    cmc_pkg::cmc_volume_type volume_req = '1, volume_applied;
    logic [8:0] rg [16] = '{default: 9'h000};
    logic [21:0] rq [$];
    logic [55:0] sq [$];
    logic [31:0] seed = 32'h0000C2C6;
    logic [23:0] s;
    logic flag_exp = 1'h0, dfr = 1'h0, rd_pend = 1'h0;
    logic [7:0] vol_exp = 8'hFF;
    int fails = 0, samples_checked = 0;
    always #2 core_clk = ~core_clk;
    cmc_host host (.core_clk(core_clk), .ctrl_wr(ctrl_wr), .ctrl_rd(ctrl_rd),
        .ctrl_addr(ctrl_addr), .ctrl_data(ctrl_data));
    cmc_ctrl DUT (.core_clk(core_clk), .rstn(rstn), .ctrl_wr(ctrl_wr), .ctrl_rd(ctrl_rd),
        .ctrl_addr(ctrl_addr), .ctrl_data(ctrl_data), .rd_data(rd_data), .in_valid(in_valid),
        .in_frame(in_frame), .volume_req(volume_req), .out_valid(out_valid),
        .out_frame(out_frame), .volume_applied(volume_applied),
        .silence_flag_pin(silence_flag_pin), .emphasis_on(emphasis_on),
        .dac_enable(dac_enable), .dac_filter_reset(dac_filter_reset), .adc_enable(adc_enable),
        .adc_filter_reset(adc_filter_reset), .adc_left_mute(adc_left_mute),
        .adc_right_mute(adc_right_mute), .reference_power_down(reference_power_down));
    // ==========
    // expected port picture from the modelled registers
    function automatic logic [21:0] expv(input logic [6:0] a);
        logic [8:0] g, c, p, m;
        g = rg[2];
        c = rg[9];
        p = rg[10];
        m = rg[12];
        return {flag_exp, p[4], m[1] | m[2], m[0] | m[2], p[0], ~p[0], g[2] | dfr,
            g[2] ? 3'h0 : ~p[3:1], c[8:6] | {3{g[1]}}, rg[a[3:0]]};
    endfunction : expv
    function automatic logic [23:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return (seed[23:0] & 24'h3FFFFF) | 24'h000001;
    endfunction : xs
    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        host.acc(1'h1, a, d);
        if (a != 7'h05) rg[a[3:0]] = d;
    endtask : wr
    // extra edge lets the derived outputs settle before the read
    task automatic rd(input logic [6:0] a);
        @(posedge core_clk);
        rq.push_back(expv(a));
        host.acc(1'h0, a, 9'h000);
    endtask : rd
    task automatic smp(input logic [23:0] v, input logic [47:0] e);
        @(posedge core_clk);
        in_valid <= 1'h1;
        in_frame <= {96'h0, v, v};
        sq.push_back({vol_exp, e});
        @(posedge core_clk);
        in_valid <= 1'h0;
        in_frame <= ~in_frame;
    endtask : smp
    task automatic cmp(input string n, input logic [55:0] e, input logic [55:0] v);
        samples_checked++;
        if (e !== v) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, v);
        end
    endtask : cmp
    // ==========
    // monitor takes the oldest note whenever a read answer or a sample appears
    always @(posedge core_clk) begin
        if (rd_pend) cmp("ports", rq.pop_front(), {silence_flag_pin, reference_power_down,
            adc_left_mute, adc_right_mute, adc_filter_reset, adc_enable, dac_filter_reset,
            dac_enable, emphasis_on, rd_data});
        if (out_valid) cmp("pair1", (sq.size() > 0) ? sq.pop_front() : 'x,
            {volume_applied.vol[0], out_frame[47:0]});
        rd_pend <= ctrl_rd;
    end
    task automatic finish_test;
        // notes never answered count as mismatches
        fails += rq.size() + sq.size();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        #40000;
        fails++;
        finish_test;
    end
    // ==========
    // main sequence
    initial begin
        repeat (3) @(posedge core_clk);
        rstn <= 1'h1;
        rd(7'h02);
        rd(7'h03);
        rd(7'h09);
        rd(7'h0A);
        rd(7'h0C);
        wr(7'h05, 9'h1FF);
        rd(7'h05);
        rd(7'h0D);
        $display("test reset done");
        s = xs();
        wr(7'h03, 9'h040);
        smp(s, {-s, -s});
        wr(7'h03, 9'h180);
        smp(s, {s, s});
        rd(7'h03);
        $display("test invert done");
        volume_req <= {6{8'h40}};
        smp(s, {s, s});
        vol_exp = 8'h40;
        smp(-s, {-s, -s});
        wr(7'h09, 9'h001);
        volume_req <= {6{8'h20}};
        vol_exp = 8'h20;
        smp(-s, {-s, -s});
        $display("test volume done");
        wr(7'h09, 9'h008);
        for (int g = 128; g > 0; g -= 8) smp(s, {2{24'((s * g) >> 7)}});
        wr(7'h09, 9'h000);
        wr(7'h02, 9'h001);
        repeat (2) smp(s, 48'h0);
        wr(7'h02, 9'h000);
        smp(s, 48'h0);
        smp(s, {2{24'((s * 8) >> 7)}});
        $display("test soft mute done");
        repeat (1030) smp(24'h000000, 48'h0);
        flag_exp = 1'h1;
        rd(7'h09);
        smp(s, {s, s});
        for (int k = 0; k < 4; k++) begin
            wr(7'h09, 9'(k << 1));
            flag_exp = (k >= 2);
            rd(7'h09);
        end
        flag_exp = 1'h0;
        $display("test zero flag done");
        wr(7'h09, 9'h140);
        rd(7'h09);
        wr(7'h02, 9'h002);
        rd(7'h02);
        for (int k = 0; k < 3; k++) begin
            wr(7'h0C, 9'(1 << k));
            rd(7'h0C);
        end
        $display("test emphasis and adc silence done");
        wr(7'h0A, 9'h004);
        rd(7'h0A);
        wr(7'h02, 9'h004);
        rd(7'h02);
        rd(7'h0A);
        wr(7'h02, 9'h000);
        dfr = 1'h1;
        rd(7'h02);
        repeat (8) @(posedge core_clk);
        dfr = 1'h0;
        rd(7'h02);
        wr(7'h0A, 9'h00F);
        rd(7'h0A);
        wr(7'h0A, 9'h01F);
        rd(7'h0A);
        repeat (4) @(posedge core_clk);
        $display("test power done");
        finish_test;
    end
endmodule : testbench
